// ---- rtl/color_sensor_result_readout.sv ----
`timescale 1ns/1ns
`include "color_readout_defs.svh"

module color_sensor_result_readout (
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              resetn,
  // Serial bus pins, sampled on core_clk
  input  wire logic                              sclIn,
  input  wire logic                              sdaIn,
  output logic                                   sdaOut,
  output logic                                   sdaOe,
  // Conversion core
  input  wire logic                              measDone,
  input  wire color_readout_pkg::channel_counts_t measCounts,
  input  wire logic                              shutdown,
  // Sensitivity settings and resulting lux per count
  input  wire color_readout_pkg::sense_cfg_t     senseCfg,
  output logic [15:0]                            luxResolution
);

  color_readout_pkg::readout_state_t s_reg;
  color_readout_pkg::readout_state_t s_next;

  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;
  logic [7:0] txNext;

  ////////////////////////////////////////////////////////////////////////////
  // Register map

  function automatic logic [7:0] readByte(
    input logic [7:0]                         code,
    input color_readout_pkg::channel_counts_t r
  );
    logic [7:0] b;
    b = `STALE_READ_BYTE;
    case (code)
      `GREEN_RESULT_LOW:     b = r.green[7:0];
      `GREEN_RESULT_HIGH:    b = r.green[15:8];
      `BLUE_RESULT_LOW:      b = r.blue[7:0];
      `BLUE_RESULT_HIGH:     b = r.blue[15:8];
      `INFRARED_RESULT_LOW:  b = r.infrared[7:0];
      `INFRARED_RESULT_HIGH: b = r.infrared[15:8];
      default:               b = `STALE_READ_BYTE;
    endcase
    return b;
  endfunction

  // Byte for the next read slot; stale pointer after a stop gives zero
  function automatic logic [7:0] nextTx(
    input color_readout_pkg::readout_state_t s
  );
    return s.cmdFresh ? readByte(s.ptr, s.results)
                      : `STALE_READ_BYTE;
  endfunction

  // Lux per count for the active settings
  function automatic logic [15:0] resolutionOf(
    input color_readout_pkg::sense_cfg_t c
  );
    logic [15:0] base;
    logic [15:0] scaled;
    base = `RES_GAIN_X2;
    unique case (c.gain)
      color_readout_pkg::GAIN_X2:   base = `RES_GAIN_X2;
      color_readout_pkg::GAIN_X1:   base = `RES_GAIN_X1;
      color_readout_pkg::GAIN_X066: base = `RES_GAIN_X066;
      color_readout_pkg::GAIN_X05:  base = `RES_GAIN_X05;
    endcase
    scaled = base << c.integrationTime;
    return c.fullArea ? scaled : {scaled[14:0], 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions

  assign sclRise   = sclIn & ~s_reg.sclPrev;
  assign sclFall   = ~sclIn & s_reg.sclPrev;
  assign startSeen = sclIn & s_reg.sclPrev & s_reg.sdaPrev & ~sdaIn;
  assign stopSeen  = sclIn & s_reg.sclPrev & ~s_reg.sdaPrev & sdaIn;

  // Byte to load at the start of each read slot
  assign txNext    = nextTx(s_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next         = s_reg;
    s_next.sclPrev = sclIn;
    s_next.sdaPrev = sdaIn;
    s_next.sdaOut  = 1'b0;
    s_next.luxResolution = resolutionOf(senseCfg);

    // Results latched only at the end of a conversion, held in shutdown
    if (measDone && !shutdown) begin
      s_next.results = measCounts;
    end

    if (stopSeen) begin
      s_next.st       = color_readout_pkg::ST_IDLE;
      s_next.sdaOe    = 1'b0;
      s_next.cmdFresh = 1'b0;
    end else if (startSeen) begin
      // A repeated start keeps the command pointer valid
      s_next.st     = color_readout_pkg::ST_RX;
      s_next.phase  = color_readout_pkg::PH_ADDR;
      s_next.bitCnt = 4'h0;
      s_next.sdaOe  = 1'b0;
    end else begin
      unique case (s_reg.st)
        color_readout_pkg::ST_IDLE: begin
          s_next.sdaOe = 1'b0;
        end
        color_readout_pkg::ST_RX: begin
          if (sclRise && s_reg.bitCnt != `BITS_PER_BYTE) begin
            s_next.shiftIn = {s_reg.shiftIn[6:0], sdaIn};
            s_next.bitCnt  = s_reg.bitCnt + 4'h1;
          end else if (sclFall && s_reg.bitCnt == `BITS_PER_BYTE) begin
            s_next.bitCnt = 4'h0;
            s_next.st     = color_readout_pkg::ST_ACK;
            s_next.sdaOe  = 1'b1;
            unique case (s_reg.phase)
              color_readout_pkg::PH_ADDR: begin
                if (s_reg.shiftIn[7:1] == `TARGET_ADDR) begin
                  s_next.readDir = s_reg.shiftIn[0];
                end else begin
                  s_next.st    = color_readout_pkg::ST_IDLE;
                  s_next.sdaOe = 1'b0;
                end
              end
              color_readout_pkg::PH_CMD: begin
                s_next.ptr      = s_reg.shiftIn;
                s_next.cmdFresh = 1'b1;
              end
              default: begin
                // Result registers are read-only; written bytes are dropped
              end
            endcase
          end
        end
        color_readout_pkg::ST_ACK: begin
          if (sclFall) begin
            if (s_reg.phase == color_readout_pkg::PH_ADDR && s_reg.readDir)
            begin
              s_next.txByte = txNext;
              s_next.sdaOe  = ~txNext[7];
              s_next.st     = color_readout_pkg::ST_TX;
            end else begin
              s_next.sdaOe = 1'b0;
              s_next.st    = color_readout_pkg::ST_RX;
              s_next.phase = (s_reg.phase == color_readout_pkg::PH_ADDR)
                             ? color_readout_pkg::PH_CMD
                             : color_readout_pkg::PH_WDATA;
            end
          end
        end
        color_readout_pkg::ST_TX: begin
          if (sclRise) begin
            s_next.bitCnt = s_reg.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (s_reg.bitCnt == `BITS_PER_BYTE) begin
              s_next.bitCnt = 4'h0;
              s_next.sdaOe  = 1'b0;
              s_next.st     = color_readout_pkg::ST_TXACK;
            end else begin
              s_next.txByte = {s_reg.txByte[6:0], 1'b0};
              s_next.sdaOe  = ~s_reg.txByte[6];
            end
          end
        end
        color_readout_pkg::ST_TXACK: begin
          if (sclRise) begin
            s_next.hostAck = ~sdaIn;
            if (!sdaIn) begin
              s_next.ptr = s_reg.ptr + 8'h01;
            end
          end else if (sclFall) begin
            if (s_reg.hostAck) begin
              s_next.txByte = txNext;
              s_next.sdaOe  = ~txNext[7];
              s_next.st     = color_readout_pkg::ST_TX;
            end else begin
              s_next.st = color_readout_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_reg               <= '0;
      s_reg.st            <= color_readout_pkg::ST_IDLE;
      s_reg.phase         <= color_readout_pkg::PH_ADDR;
      s_reg.sclPrev       <= 1'b1;
      s_reg.sdaPrev       <= 1'b1;
      s_reg.results       <= {`RESULT_RESET, `RESULT_RESET, `RESULT_RESET};
      s_reg.luxResolution <= `RES_GAIN_X2;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sdaOut        = s_reg.sdaOut;
  assign sdaOe         = s_reg.sdaOe;
  assign luxResolution = s_reg.luxResolution;

endmodule // color_sensor_result_readout

// ---- rtl/color_readout_defs.svh ----
`ifndef COLOR_READOUT_DEFS_SVH
`define COLOR_READOUT_DEFS_SVH

// Target address on the serial bus
`define TARGET_ADDR         7'h29

// Result command codes
`define GREEN_RESULT_LOW    8'h12
`define GREEN_RESULT_HIGH   8'h13
`define BLUE_RESULT_LOW     8'h14
`define BLUE_RESULT_HIGH    8'h15
`define INFRARED_RESULT_LOW  8'h16
`define INFRARED_RESULT_HIGH 8'h17

// Value returned when the read phase follows a stop
`define STALE_READ_BYTE     8'h00

// Result reset value
`define RESULT_RESET        16'h0000

// Bits per byte on the bus
`define BITS_PER_BYTE       4'h8

// Lux per count at the longest integration time, in units of 0.1 mlx
`define RES_GAIN_X2         16'h0035
`define RES_GAIN_X1         16'h0069
`define RES_GAIN_X066       16'h009F
`define RES_GAIN_X05        16'h00D2

`endif

// ---- rtl/color_readout_pkg.sv ----
package color_readout_pkg;

  // Link states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } link_state_t;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    PH_ADDR,
    PH_CMD,
    PH_WDATA
  } rx_phase_t;

  // Integration time 400 ms down to 3.125 ms
  typedef enum logic [2:0] {
    IT_400MS,
    IT_200MS,
    IT_100MS,
    IT_50MS,
    IT_25MS,
    IT_12P5MS,
    IT_6P25MS,
    IT_3P125MS
  } integration_time_t;

  typedef enum logic [1:0] {
    GAIN_X2,
    GAIN_X1,
    GAIN_X066,
    GAIN_X05
  } channel_gain_select_t;

  // Counts handed over by the conversion core
  typedef struct packed {
    logic [15:0] green;
    logic [15:0] blue;
    logic [15:0] infrared;
  } channel_counts_t;

  // Sensitivity settings
  typedef struct packed {
    integration_time_t    integrationTime;
    channel_gain_select_t gain;
    logic                 fullArea;
  } sense_cfg_t;

  // Whole state of the readout block
  typedef struct packed {
    link_state_t     st;
    rx_phase_t       phase;
    logic [3:0]      bitCnt;
    logic [7:0]      shiftIn;
    logic [7:0]      txByte;
    logic [7:0]      ptr;
    logic            cmdFresh;
    logic            readDir;
    logic            hostAck;
    logic            sclPrev;
    logic            sdaPrev;
    logic            sdaOe;
    logic            sdaOut;
    channel_counts_t results;
    logic [15:0]     luxResolution;
  } readout_state_t;

endpackage

// ---- tb/i2c_host_model.sv ----
`timescale 1ns/1ns
module i2c_host_model (
  // Clock and bus line
  input  wire logic clk,
  input  wire logic sda,
  // Host drives
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic pin(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    sdaLow <= ~d;
    repeat (4) @(posedge clk);
  endtask
  task automatic bitx(input logic d, output logic q);
    pin(1'b0, d);
    pin(1'b1, d);
    q = sda;
    pin(1'b0, d);
  endtask
  task automatic st;
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
  endtask
  task automatic sp;
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
  endtask
  task automatic wb(input logic [7:0] b, output logic ak);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], q);
    end
    bitx(1'b1, q);
    ak = ~q;
  endtask
  // Command write, then read of n bytes, low byte first
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    input logic stp, input int n,
                    output logic [31:0] d, output logic ak);
    logic a0, a1, a2, q;
    d = '0;
    st();
    wb({a, 1'b0}, a0);
    wb(c, a1);
    if (stp) begin
      sp();
    end
    st();
    wb({a, 1'b1}, a2);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bitx(1'b1, q);
        d[8*k+i] = q;
      end
      bitx(k == n - 1, q);
    end
    sp();
    ak = a0 & a1 & a2;
  endtask
endmodule // i2c_host_model

// ---- tb/color_readout_asserts.sv ----
`timescale 1ns/1ns
`include "color_readout_defs.svh"
module color_readout_asserts (
  // Clock and reset
  input wire logic                              core_clk,
  input wire logic                              resetn,
  // Bus pins
  input wire logic                              sclIn,
  input wire logic                              sdaIn,
  input wire logic                              sdaOut,
  input wire logic                              sdaOe,
  // Core side
  input wire logic                              measDone,
  input wire color_readout_pkg::channel_counts_t measCounts,
  input wire logic                              shutdown,
  input wire color_readout_pkg::sense_cfg_t     senseCfg,
  input wire logic [15:0]                       luxResolution
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  function automatic logic [15:0] res(color_readout_pkg::sense_cfg_t c);
    logic [15:0] b [4];
    b = '{`RES_GAIN_X2, `RES_GAIN_X1, `RES_GAIN_X066, `RES_GAIN_X05};
    return (b[c.gain] << c.integrationTime) << !c.fullArea;
  endfunction
  ////////////////////////////////////////////////////////////
  a_sda_zero: assert property (sdaOut == 1'b0)
    else $error("data drive value not zero");
  a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data pin changed while clock high");
  a_rst_quiet: assert property ($rose(resetn) |-> !sdaOe [*8])
    else $error("data pin driven after reset");
  a_start_quiet: assert property (
    sclIn && $fell(sdaIn) |=> !sdaOe [*8])
    else $error("data pin driven right after start");
  a_stop_quiet: assert property (
    sclIn && $rose(sdaIn) |=> !sdaOe [*8])
    else $error("data pin driven right after stop");
  a_lux_reset: assert property (
    $rose(resetn) |-> luxResolution == `RES_GAIN_X2)
    else $error("lux resolution reset value wrong");
  a_lux_full: assert property (
    $past(resetn) && $past(senseCfg.fullArea)
    |-> luxResolution == res($past(senseCfg)))
    else $error("lux resolution wrong at full area");
  a_lux_half: assert property (
    $past(resetn) && !$past(senseCfg.fullArea)
    |-> luxResolution == res($past(senseCfg)))
    else $error("lux resolution wrong at half area");
  cover property ($rose(sdaOe));
  cover property (sclIn && $rose(sdaIn));
  cover property (!senseCfg.fullArea);
endmodule // color_readout_asserts
bind color_sensor_result_readout color_readout_asserts
  i_color_readout_asserts (
  .core_clk(core_clk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .measDone(measDone),
  .measCounts(measCounts), .shutdown(shutdown), .senseCfg(senseCfg),
  .luxResolution(luxResolution));

// ---- tb/test_color_sensor_result_readout.sv ----
`timescale 1ns/1ns
`include "color_readout_defs.svh"
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("Error %s exp %h got %h", nm, e, g); \
  end \
end
module test_color_sensor_result_readout;
  logic                               core_clk = 1'b0;
  logic                               resetn = 1'b0;
  logic                               measDone = 1'b0;
  logic                               shutdown = 1'b0;
  color_readout_pkg::channel_counts_t measCounts = '0;
  color_readout_pkg::sense_cfg_t      senseCfg = '0;
  logic                               scl, sdaLow, sdaOe, sdaOut, ak;
  logic [15:0]                        luxResolution;
  logic [31:0]                        d;
  int                                 n_mismatch = 0;
  int                                 num_checks = 0;
  // Open-drain line with pull-up
  wire sda = ~(sdaLow | (sdaOe & ~sdaOut));
  always #2 core_clk = ~core_clk;
  color_sensor_result_readout i_color_sensor_result_readout (
    .core_clk(core_clk), .resetn(resetn), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .measDone(measDone),
    .measCounts(measCounts), .shutdown(shutdown),
    .senseCfg(senseCfg), .luxResolution(luxResolution));
  i2c_host_model i_i2c_host_model (
    .clk(core_clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
  ////////////////////////////////////////////////////////////
  task automatic load(input logic [47:0] v);
    @(posedge core_clk);
    measDone <= 1'b1;
    measCounts <= v;
    @(posedge core_clk);
    measDone <= 1'b0;
    measCounts <= ~v;
  endtask
  task automatic t_channels;
    load(48'hA5C3_1234_80FF);
    i_i2c_host_model.rd(`TARGET_ADDR, `GREEN_RESULT_LOW, 1'b0, 3, d, ak);
    `CHK("ack", 1'b1, ak)
    `CHK("green", 16'hA5C3, d[15:0])
    `CHK("blue low", 8'h34, d[23:16])
    i_i2c_host_model.rd(`TARGET_ADDR, `BLUE_RESULT_HIGH, 1'b0, 4, d, ak);
    `CHK("blue high", 8'h12, d[7:0])
    `CHK("infrared", 16'h80FF, d[23:8])
    `CHK("unmapped", `STALE_READ_BYTE, d[31:24])
    $display("t_channels done");
  endtask
  task automatic t_stop;
    i_i2c_host_model.rd(`TARGET_ADDR, `GREEN_RESULT_LOW, 1'b1, 2, d, ak);
    `CHK("stale", {2{`STALE_READ_BYTE}}, d[15:0])
    i_i2c_host_model.rd(7'h2A, `GREEN_RESULT_LOW, 1'b0, 1, d, ak);
    `CHK("other addr ack", 1'b0, ak)
    `CHK("other addr data", 8'hFF, d[7:0])
    $display("t_stop done");
  endtask
  task automatic t_hold;
    @(posedge core_clk);
    shutdown <= 1'b1;
    load(48'h1111_2222_3333);
    i_i2c_host_model.rd(`TARGET_ADDR, `GREEN_RESULT_LOW, 1'b0, 2, d, ak);
    `CHK("held green", 16'hA5C3, d[15:0])
    @(posedge core_clk);
    shutdown <= 1'b0;
    $display("t_hold done");
  endtask
  task automatic t_lux;
    logic [15:0] b [4];
    logic [15:0] e;
    b = '{`RES_GAIN_X2, `RES_GAIN_X1, `RES_GAIN_X066, `RES_GAIN_X05};
    for (int k = 0; k < 33; k++) begin
      @(posedge core_clk);
      senseCfg <= {k[4:0], k != 32};
      repeat (2) @(posedge core_clk);
      e = (b[k % 4] << (k / 4 % 8)) << (k / 32);
      `CHK("lux", e, luxResolution)
    end
    $display("t_lux done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_channels();
    t_stop();
    t_hold();
    t_lux();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
endmodule // test_color_sensor_result_readout
